// ### design/cfg_pkg.sv
`default_nettype none
package cfg_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_BITS = 6;
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOAD_TIME_US = 100;
    localparam int LOAD_CYCLES = (LOAD_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int IR_W = 8;
    localparam int DR_W = 32;
    localparam int USERCODE_WORD = 0;
    localparam int PIN_WORD = 1;
    localparam int SEC_READ_BIT = 0;
    localparam int SEC_WRITE_BIT = 1;
    localparam logic [IR_W-1:0] IR_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] IR_SAMPLE = 8'h01;
    localparam logic [IR_W-1:0] IR_INTEST = 8'h02;
    localparam logic [IR_W-1:0] IR_ISC_ENABLE = 8'he8;
    localparam logic [IR_W-1:0] IR_ISC_UNLOCK = 8'he9;
    localparam logic [IR_W-1:0] IR_ISC_PROGRAM = 8'hea;
    localparam logic [IR_W-1:0] IR_ISC_ERASE = 8'hed;
    localparam logic [IR_W-1:0] IR_ISC_READ = 8'hee;
    localparam logic [IR_W-1:0] IR_ISC_DISABLE = 8'hf0;
    localparam logic [IR_W-1:0] IR_CLAMP = 8'hfa;
    localparam logic [IR_W-1:0] IR_HIGHZ = 8'hfc;
    localparam logic [IR_W-1:0] IR_USERCODE = 8'hfd;
    localparam logic [IR_W-1:0] IR_IDCODE = 8'hfe;
    localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
    localparam logic [15:0] UNLOCK_KEY = 16'h5aa5;

    typedef enum logic [1:0] {
        OP_PROGRAM = 2'h0,
        OP_READ = 2'h1,
        OP_ERASE = 2'h2,
        OP_UNLOCK = 2'h3
    } isc_op_t;

    typedef enum logic [2:0] {
        PM_USER = 3'h0,
        PM_HIGHZ = 3'h1,
        PM_EXTEST = 3'h2,
        PM_INTEST = 3'h3,
        PM_CLAMP = 3'h4,
        PM_PROG = 3'h5
    } pin_mode_t;

    typedef enum logic [1:0] {
        LD_CLEAR = 2'h0,
        LD_SECURITY = 2'h1,
        LD_LOAD = 2'h2,
        LD_RUN = 2'h3
    } load_state_t;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
        TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
    } tap_state_t;
endpackage : cfg_pkg
`default_nettype wire

// ### design/cpld_config_controller.sv
// Contract
// - Devices chain serially; each programs through the four-signal test port.
// - During in-field programming all pins float, pulled High.
// - Test port decodes the eight standard instructions plus private programming ones.
// - Two independent protection bits: read and write, four combinations.
// - Read protection refuses any readout of the stored pattern; USERCODE still returns word 0 while sec_r is set.
// - Read protection blocks programming but still allows erase.
// - Only a full erase clears read protection; reset_i also clears it here, since nv_r resets to 0.
// - Write protection blocks erase/program until the host's unlock sequence.
// - Below safe supply: pins and test port disabled, outputs off, pulled High.
// - After supply is safe, registers initialise and device runs once the load sequence ends.
// - Erased device: outputs off with pull-ups, test port enabled.
// - Programmed device: configured pin behaviour, test port stays enabled.
// - Inputs and logic blocks off until user operation; keepers pull up till then. INTEST here feeds bsr_c to user_in_o and enables logic blocks if prog.
// - Internally clocked state machine loads configuration after power-on detect.
// - Every load sequence first resets all configuration latches.
// - Controller steps addresses, strobes latches, finally enables pins.
// - Whole bit transfer takes about one hundred microseconds.
// - Outside user operation keepers act as weak pull-ups.
`default_nettype none
module cpld_config_controller
    import cfg_pkg::*;
#(
    parameter int PIN_N = PIN_COUNT,
    parameter int ADDR_W = ADDR_BITS,
    parameter logic [31:0] ID_CODE = 32'h0f00_0001 // Arbitrary identity value
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [PIN_N-1:0] pin_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [PIN_N-1:0] pin_out_o,
    output logic [PIN_N-1:0] pin_oe_o,
    output logic [PIN_N-1:0] pin_pullup_o,
    output logic [PIN_N-1:0] user_in_o,
    output logic logic_block_en_o,
    output logic config_ready_o
);
    localparam int DATA_W = 2 * PIN_N;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int ISC_W = 1 + ADDR_W + DATA_W;
    localparam int WORD_CYCLES = LOAD_CYCLES / DEPTH;
    localparam int WAIT_W = $clog2(WORD_CYCLES + 1);
    localparam logic [ADDR_W-1:0] SEC_ADDR = '1;
    localparam int CS_W = 2 + 3 + PIN_N + PIN_N;
    localparam int TS_W = 2 + PIN_N + DATA_W;

    // Link-clock (test port) domain
    tap_state_t tap, next_tap;
    logic [IR_W-1:0] ir, next_ir, ir_sh, next_ir_sh;
    logic [DR_W-1:0] dr, next_dr;
    logic isc, next_isc, req_tog, next_req_tog;
    isc_op_t op, next_op;
    logic [ADDR_W-1:0] op_addr, next_op_addr;
    logic [DATA_W-1:0] op_data, next_op_data;
    logic [PIN_N-1:0] bsr_upd, next_bsr_upd;
    pin_mode_t mode_t, next_mode_t;
    logic [TS_W-1:0] ts1, ts2;
    logic en_t, ack_t, busy;
    logic [PIN_N-1:0] pins_t;
    logic [DATA_W-1:0] user_t;
    int dr_len;

    // Core clock domain
    load_state_t ld_state, next_ld_state;
    logic [ADDR_W-1:0] ld_addr, next_ld_addr;
    logic [WAIT_W-1:0] ld_wait, next_ld_wait;
    logic [DATA_W-1:0] nv [DEPTH];
    logic [DATA_W-1:0] cfg [DEPTH];
    logic nv_r, next_nv_r, nv_w, next_nv_w, nv_prog, next_nv_prog;
    logic sec_r, next_sec_r, sec_w, next_sec_w, prog, next_prog;
    logic unlocked, next_unlocked, ack_tog, next_ack_tog;
    logic res_ok, next_res_ok, jtag_en, next_jtag_en;
    logic [DATA_W-1:0] res_data, next_res_data;
    logic isc_prev;
    logic clear_cfg, load_strobe, mem_we, mem_erase;
    logic [CS_W-1:0] cs1, cs2;
    logic req_c, isc_c;
    pin_mode_t mode_c;
    logic [PIN_N-1:0] bsr_c, pins_c;
    logic [PIN_N-1:0] next_out, next_oe, next_pullup, next_user_in;
    logic next_lb_en, next_ready;

    // Link-clock side of the crossings; two-stage synchronisers, and pin_i is sampled free-running, not held stable by the handshake
    always_ff @(posedge tck_i or posedge reset_i) begin
        if (reset_i) begin
            ts1 <= '0;
            ts2 <= '0;
        end else begin
            ts1 <= {jtag_en, ack_tog, pin_i, cfg[USERCODE_WORD]};
            ts2 <= ts1;
        end
    end
    assign {en_t, ack_t, pins_t, user_t} = ts2;
    assign busy = req_tog != ack_t;

    always_comb begin
        case (ir)
            IR_IDCODE, IR_USERCODE: dr_len = DR_W;
            IR_EXTEST, IR_SAMPLE, IR_INTEST: dr_len = PIN_N;
            IR_ISC_PROGRAM, IR_ISC_READ, IR_ISC_ERASE, IR_ISC_UNLOCK: dr_len = ISC_W;
            default: dr_len = 1;
        endcase
    end

    always_comb begin
        next_tap = tap;
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_dr = dr;
        next_isc = isc;
        next_req_tog = req_tog;
        next_op = op;
        next_op_addr = op_addr;
        next_op_data = op_data;
        next_bsr_upd = bsr_upd;
        case (tap)
            TAP_RESET: next_tap = tms_i ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = tms_i ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR, TAP_SH_DR: next_tap = tms_i ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_tap = tms_i ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: next_tap = tms_i ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: next_tap = tms_i ? TAP_UPD_DR : TAP_SH_DR;
            TAP_SEL_IR: next_tap = tms_i ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR, TAP_SH_IR: next_tap = tms_i ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_tap = tms_i ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: next_tap = tms_i ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: next_tap = tms_i ? TAP_UPD_IR : TAP_SH_IR;
            default: next_tap = tms_i ? TAP_SEL_DR : TAP_IDLE;
        endcase
        case (tap)
            TAP_RESET: next_ir = IR_IDCODE;
            TAP_CAP_IR: next_ir_sh = IR_CAPTURE;
            TAP_SH_IR: next_ir_sh = {tdi_i, ir_sh[IR_W-1:1]};
            TAP_UPD_IR: begin
                next_ir = ir_sh;
                if (ir_sh == IR_ISC_ENABLE) begin
                    next_isc = 1'b1;
                end else if (ir_sh == IR_ISC_DISABLE) begin
                    next_isc = 1'b0;
                end
            end
            TAP_CAP_DR: begin
                case (ir)
                    IR_IDCODE: next_dr = ID_CODE;
                    IR_USERCODE: next_dr = DR_W'(user_t);
                    IR_EXTEST, IR_SAMPLE, IR_INTEST: next_dr = DR_W'(pins_t);
                    IR_ISC_PROGRAM, IR_ISC_READ, IR_ISC_ERASE, IR_ISC_UNLOCK:
                        next_dr = DR_W'({res_ok & ~busy, op_addr, res_data});
                    default: next_dr = '0;
                endcase
            end
            TAP_SH_DR: begin
                next_dr = dr >> 1;
                next_dr[dr_len-1] = tdi_i;
            end
            TAP_UPD_DR: begin
                if (dr_len == PIN_N) begin
                    next_bsr_upd = dr[PIN_N-1:0];
                end
                // A request while the previous one is in flight is dropped
                if (dr_len == ISC_W && isc && !busy) begin
                    next_op_addr = dr[ADDR_W+DATA_W-1:DATA_W];
                    next_op_data = dr[DATA_W-1:0];
                    next_req_tog = ~req_tog;
                    case (ir)
                        IR_ISC_PROGRAM: next_op = OP_PROGRAM;
                        IR_ISC_READ: next_op = OP_READ;
                        IR_ISC_ERASE: next_op = OP_ERASE;
                        default: next_op = OP_UNLOCK;
                    endcase
                end
            end
            default: next_ir = ir;
        endcase
        if (!en_t) begin
            next_tap = TAP_RESET;
        end
        if (isc) begin
            next_mode_t = PM_PROG;
        end else begin
            case (ir)
                IR_HIGHZ: next_mode_t = PM_HIGHZ;
                IR_EXTEST: next_mode_t = PM_EXTEST;
                IR_INTEST: next_mode_t = PM_INTEST;
                IR_CLAMP: next_mode_t = PM_CLAMP;
                default: next_mode_t = PM_USER;
            endcase
        end
    end

    always_ff @(posedge tck_i or posedge reset_i) begin
        if (reset_i) begin
            tap <= TAP_RESET;
            ir <= IR_IDCODE;
            ir_sh <= '0;
            dr <= '0;
            isc <= 1'b0;
            req_tog <= 1'b0;
            op <= OP_READ;
            op_addr <= '0;
            op_data <= '0;
            bsr_upd <= '0;
            mode_t <= PM_USER;
        end else begin
            tap <= next_tap;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            dr <= next_dr;
            isc <= next_isc;
            req_tog <= next_req_tog;
            op <= next_op;
            op_addr <= next_op_addr;
            op_data <= next_op_data;
            bsr_upd <= next_bsr_upd;
            mode_t <= next_mode_t;
        end
    end

    // Serial output changes on the falling edge so the host samples it mid-bit
    always_ff @(negedge tck_i or posedge reset_i) begin
        if (reset_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o <= (tap == TAP_SH_IR) ? ir_sh[0] : dr[0];
            tdo_oe_o <= (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
        end
    end

    // Core side of the crossings
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cs1 <= '0;
            cs2 <= '0;
            isc_prev <= 1'b0;
        end else begin
            cs1 <= {req_tog, isc, mode_t, bsr_upd, pin_i};
            cs2 <= cs1;
            isc_prev <= isc_c;
        end
    end
    assign {req_c, isc_c, mode_c, bsr_c, pins_c} = cs2;

    always_comb begin
        next_ld_state = ld_state;
        next_ld_addr = ld_addr;
        next_ld_wait = ld_wait;
        next_nv_r = nv_r;
        next_nv_w = nv_w;
        next_nv_prog = nv_prog;
        next_sec_r = sec_r;
        next_sec_w = sec_w;
        next_prog = prog;
        next_unlocked = unlocked;
        next_ack_tog = ack_tog;
        next_res_ok = res_ok;
        next_res_data = res_data;
        clear_cfg = 1'b0;
        load_strobe = 1'b0;
        mem_we = 1'b0;
        mem_erase = 1'b0;
        case (ld_state)
            LD_CLEAR: begin
                clear_cfg = 1'b1;
                next_ld_addr = '0;
                next_ld_wait = '0;
                next_ld_state = LD_SECURITY;
            end
            LD_SECURITY: begin
                next_sec_r = nv_r;
                next_sec_w = nv_w;
                next_prog = nv_prog;
                next_ld_state = LD_LOAD;
            end
            LD_LOAD: begin
                // Word pacing spreads the array over the nominal load time
                if (ld_wait == WAIT_W'(WORD_CYCLES - 1)) begin
                    load_strobe = 1'b1;
                    next_ld_wait = '0;
                    next_ld_addr = ld_addr + 1'b1;
                    if (ld_addr == SEC_ADDR) begin
                        next_ld_state = LD_RUN;
                    end
                end else begin
                    next_ld_wait = ld_wait + 1'b1;
                end
            end
            LD_RUN: begin
                if (isc_prev && !isc_c) begin
                    next_unlocked = 1'b0;
                    next_ld_state = LD_CLEAR;
                end else if (req_c != ack_tog) begin
                    next_ack_tog = ~ack_tog;
                    next_res_data = '0;
                    case (op)
                        OP_READ: begin
                            next_res_ok = isc_c && !sec_r;
                            if (isc_c && !sec_r) begin
                                next_res_data = nv[op_addr];
                            end
                        end
                        OP_PROGRAM: begin
                            next_res_ok = isc_c && !sec_r && (!sec_w || unlocked);
                            if (isc_c && !sec_r && (!sec_w || unlocked)) begin
                                if (op_addr == SEC_ADDR) begin
                                    next_nv_r = nv_r | op_data[SEC_READ_BIT];
                                    next_nv_w = nv_w | op_data[SEC_WRITE_BIT];
                                    next_sec_r = sec_r | op_data[SEC_READ_BIT];
                                    next_sec_w = sec_w | op_data[SEC_WRITE_BIT];
                                end else begin
                                    mem_we = 1'b1;
                                    next_nv_prog = 1'b1;
                                end
                            end
                        end
                        OP_ERASE: begin
                            next_res_ok = isc_c && (!sec_w || unlocked);
                            if (isc_c && (!sec_w || unlocked)) begin
                                mem_erase = 1'b1;
                                next_nv_r = 1'b0;
                                next_nv_w = 1'b0;
                                next_nv_prog = 1'b0;
                                next_sec_r = 1'b0;
                                next_sec_w = 1'b0;
                            end
                        end
                        default: begin
                            next_res_ok = isc_c && (op_data == UNLOCK_KEY);
                            next_unlocked = isc_c && (op_data == UNLOCK_KEY);
                        end
                    endcase
                end
            end
            default: next_ld_state = LD_CLEAR;
        endcase
    end

    always_comb begin
        next_out = '0;
        next_oe = '0;
        next_pullup = '1;
        next_user_in = '0;
        next_lb_en = 1'b0;
        next_ready = ld_state == LD_RUN;
        next_jtag_en = jtag_en || (ld_state == LD_RUN);
        if (ld_state == LD_RUN) begin
            case (mode_c)
                PM_USER: begin
                    if (prog) begin
                        next_out = cfg[PIN_WORD][PIN_N-1:0];
                        next_oe = cfg[PIN_WORD][DATA_W-1:PIN_N];
                        next_pullup = '0;
                        next_user_in = pins_c;
                        next_lb_en = 1'b1;
                    end
                end
                PM_EXTEST, PM_CLAMP: begin
                    next_out = bsr_c;
                    next_oe = '1;
                    // Keepers stay pulled up: a boundary test is not user operation
                end
                PM_INTEST: begin
                    next_user_in = bsr_c;
                    next_lb_en = prog;
                end
                default: next_oe = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ld_state <= LD_CLEAR;
            ld_addr <= '0;
            ld_wait <= '0;
            nv_r <= 1'b0;
            nv_w <= 1'b0;
            nv_prog <= 1'b0;
            sec_r <= 1'b1;
            sec_w <= 1'b1;
            prog <= 1'b0;
            unlocked <= 1'b0;
            ack_tog <= 1'b0;
            res_ok <= 1'b0;
            res_data <= '0;
            jtag_en <= 1'b0;
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pin_pullup_o <= '1;
            user_in_o <= '0;
            logic_block_en_o <= 1'b0;
            config_ready_o <= 1'b0;
        end else begin
            ld_state <= next_ld_state;
            ld_addr <= next_ld_addr;
            ld_wait <= next_ld_wait;
            nv_r <= next_nv_r;
            nv_w <= next_nv_w;
            nv_prog <= next_nv_prog;
            sec_r <= next_sec_r;
            sec_w <= next_sec_w;
            prog <= next_prog;
            unlocked <= next_unlocked;
            ack_tog <= next_ack_tog;
            res_ok <= next_res_ok;
            res_data <= next_res_data;
            jtag_en <= next_jtag_en;
            pin_out_o <= next_out;
            pin_oe_o <= next_oe;
            pin_pullup_o <= next_pullup;
            user_in_o <= next_user_in;
            logic_block_en_o <= next_lb_en;
            config_ready_o <= next_ready;
        end
    end

    // Storage arrays; the nonvolatile array survives the core reset on purpose
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (clear_cfg) begin
                cfg[i] <= '0;
            end
            if (mem_erase) begin
                nv[i] <= '0;
            end
        end
        if (load_strobe) begin
            cfg[ld_addr] <= nv[ld_addr];
        end
        if (mem_we) begin
            nv[op_addr] <= op_data;
        end
    end
endmodule : cpld_config_controller
`default_nettype wire

// ### test/cfg_load_checker_sva.sv
`default_nettype none
module cfg_load_checker
    import cfg_pkg::*;
#(
    parameter int PIN_N = PIN_COUNT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [PIN_N-1:0] pin_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [PIN_N-1:0] pin_out_o,
    input wire logic [PIN_N-1:0] pin_oe_o,
    input wire logic [PIN_N-1:0] pin_pullup_o,
    input wire logic [PIN_N-1:0] user_in_o,
    input wire logic logic_block_en_o,
    input wire logic config_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOAD_MIN = 1900;
    localparam int LOAD_MAX = 2100;
    logic [11:0] wait_cnt;
    logic [11:0] next_wait_cnt;
    logic seen_ready;
    logic next_seen_ready;
    always_comb begin
        next_wait_cnt = config_ready_o ? 12'h000 : wait_cnt + 12'h001;
        next_seen_ready = seen_ready | config_ready_o;
    end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wait_cnt <= 12'h000;
            seen_ready <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            seen_ready <= next_seen_ready;
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    pullup_outside_user_a: assert property (!logic_block_en_o |-> pin_pullup_o == '1)
        else $error("keeper not pulled up outside user operation");
    inputs_off_a: assert property (!logic_block_en_o |-> user_in_o == '0)
        else $error("inputs reach logic blocks while disabled");
    outputs_off_a: assert property (!config_ready_o |-> pin_oe_o == '0)
        else $error("pin driven before load finished");
    user_after_load_a: assert property (logic_block_en_o |-> config_ready_o)
        else $error("logic blocks on before load finished");
    load_time_a: assert property ($rose(config_ready_o) |->
        wait_cnt >= LOAD_MIN && wait_cnt <= LOAD_MAX)
        else $error("load sequence length out of range");
    port_quiet_a: assert property (!seen_ready |-> !tdo_oe_o)
        else $error("test port active before first load");
    bus_hold_user_a: assert property (
        $changed(pin_pullup_o) && pin_pullup_o == '0 |-> logic_block_en_o && config_ready_o)
        else $error("keeper in bus-hold outside user operation");
    inputs_follow_a: assert property (
        (logic_block_en_o && pin_pullup_o == '0 && $stable(pin_i))[*4] |-> user_in_o == pin_i)
        else $error("user inputs do not follow pins");
endmodule : cfg_load_checker
bind cpld_config_controller cfg_load_checker #(.PIN_N(PIN_N)) i_chk (.clock_i(clock_i),
    .reset_i(reset_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .pin_i(pin_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .user_in_o(user_in_o),
    .logic_block_en_o(logic_block_en_o), .config_ready_o(config_ready_o));
`default_nettype wire

// ### test/jtag_host_model.sv
`default_nettype none
module jtag_host_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cap;
    event cap_ev;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // Test clock only runs inside a frame and rests low between requests
    task automatic tick(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #16;
        q = tdo_i;
        tck_o = 1'b1;
        #16;
        tck_o = 1'b0;
    endtask : tick
    task automatic reset_tap();
        logic q;
        repeat (6) tick(1'b1, ~tdi_o, q);
        tick(1'b0, ~tdi_o, q);
    endtask : reset_tap
    // Whole request over the four signals, LSB first, back to idle
    task automatic scan(input logic is_ir, input logic [31:0] v, input int len,
        input logic want);
        logic q;
        tick(1'b1, ~tdi_o, q);
        if (is_ir) tick(1'b1, ~tdi_o, q);
        tick(1'b0, ~tdi_o, q);
        tick(1'b0, ~tdi_o, q);
        cap = '0;
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, v[i], q);
            cap[i] = q;
        end
        tick(1'b1, ~tdi_o, q);
        tick(1'b0, ~tdi_o, q);
        // Idle edges let the core answer cross back; gap keeps updates 1 us apart
        repeat (8) tick(1'b0, ~tdi_o, q);
        #1100;
        if (want) ->cap_ev;
    endtask : scan
endmodule : jtag_host_model
`default_nettype wire

// ### test/cpld_powerup_config_security_tb_top.sv
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module cpld_powerup_config_security_tb_top
    import cfg_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID_VAL = 32'h2c4a_6e81; // Arbitrary identity value
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, logic_block_en_o, config_ready_o;
    logic [7:0] pin_i = 8'h00;
    logic [7:0] pin_out_o, pin_oe_o, pin_pullup_o, user_in_o;
    int errors = 0;
    int n_compared = 0;
    int seed;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] cur_e, cur_m;
    logic [15:0] v1, v3, v4;
    always #25 clock_i = ~clock_i;
    cpld_config_controller #(.ID_CODE(ID_VAL)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
        .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .pin_i(pin_i), .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pin_pullup_o(pin_pullup_o), .user_in_o(user_in_o),
        .logic_block_en_o(logic_block_en_o), .config_ready_o(config_ready_o));
    jtag_host_model i_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
    task automatic final_report();
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic wait_ready(input int lo);
        int n;
        n = 0;
        while (config_ready_o !== 1'b1 && n < 3000) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            final_report();
        end else `CHK(n >= lo && n <= 2100, 1'b1)
    endtask : wait_ready
    task automatic ir(input logic [7:0] c);
        i_host.scan(1'b1, {24'h0, c}, 8, 1'b0);
    endtask : ir
    task automatic req(input logic [7:0] c, input logic [5:0] a, input logic [15:0] d);
        ir(c);
        i_host.scan(1'b0, {10'h0, a, d}, 23, 1'b0);
    endtask : req
    // Read answer arrives in the capture of the following scan
    task automatic rd(input logic [5:0] a, input logic [22:0] e, input logic [22:0] m);
        exp_q.push_back({9'h0, e});
        msk_q.push_back({9'h0, m});
        req(IR_ISC_READ, a, 16'h0000);
        i_host.scan(1'b0, {10'h0, a, 16'h0000}, 23, 1'b1);
    endtask : rd
    always @(i_host.cap_ev) begin
        cur_m = msk_q.pop_front();
        cur_e = exp_q.pop_front();
        `CHK(i_host.cap & cur_m, cur_e)
    end
    initial begin
        seed = 32'hb070;
        repeat (20) @(negedge clock_i);
        `CHK(pin_oe_o, 8'h00)
        `CHK(pin_pullup_o, 8'hff)
        `CHK({tdo_oe_o, logic_block_en_o, config_ready_o}, 3'b000)
        reset_i = 1'b0;
        wait_ready(1900);
        i_host.reset_tap();
        exp_q.push_back(ID_VAL);
        msk_q.push_back(32'hffff_ffff);
        i_host.scan(1'b0, 32'h0, 32, 1'b1);
        {v1, v3} = $random(seed);
        v4 = 16'($random(seed));
        ir(IR_ISC_ENABLE);
        req(IR_ISC_ERASE, 6'h00, 16'h0000);
        req(IR_ISC_PROGRAM, 6'h01, v1);
        rd(6'h01, {1'b1, 6'h01, v1}, 23'h7fffff);
        req(IR_ISC_PROGRAM, 6'h3f, 16'h0001);
        rd(6'h01, 23'h000000, 23'h40ffff);
        // A program refused under read protection answers with ok low
        exp_q.push_back(32'h0);
        msk_q.push_back(32'h0040_0000);
        req(IR_ISC_PROGRAM, 6'h01, ~v1);
        i_host.scan(1'b0, 32'h0, 23, 1'b1);
        req(IR_ISC_ERASE, 6'h00, 16'h0000);
        req(IR_ISC_PROGRAM, 6'h01, v3);
        rd(6'h01, {1'b1, 6'h01, v3}, 23'h7fffff);
        req(IR_ISC_PROGRAM, 6'h3f, 16'h0002);
        req(IR_ISC_ERASE, 6'h00, 16'h0000);
        req(IR_ISC_PROGRAM, 6'h01, ~v3);
        rd(6'h01, {1'b1, 6'h01, v3}, 23'h7fffff);
        req(IR_ISC_UNLOCK, 6'h00, UNLOCK_KEY);
        req(IR_ISC_ERASE, 6'h00, 16'h0000);
        req(IR_ISC_PROGRAM, 6'h01, v4);
        rd(6'h01, {1'b1, 6'h01, v4}, 23'h7fffff);
        req(IR_ISC_PROGRAM, 6'h00, v3);
        ir(IR_ISC_DISABLE);
        wait_ready(1800);
        pin_i = 8'($random(seed));
        repeat (8) @(negedge clock_i);
        `CHK(pin_out_o, v4[7:0])
        `CHK(pin_oe_o, v4[15:8])
        `CHK({pin_pullup_o, logic_block_en_o}, 9'h001)
        `CHK(user_in_o, pin_i)
        ir(IR_USERCODE);
        exp_q.push_back({16'h0, v3});
        msk_q.push_back(32'hffff_ffff);
        i_host.scan(1'b0, 32'h0, 32, 1'b1);
        ir(IR_HIGHZ);
        repeat (4) @(negedge clock_i);
        `CHK({pin_oe_o, pin_pullup_o}, 16'h00ff)
        ir(IR_ISC_ENABLE);
        repeat (4) @(negedge clock_i);
        `CHK({pin_oe_o, pin_pullup_o, logic_block_en_o}, 17'h001fe)
        final_report();
    end
endmodule : cpld_powerup_config_security_tb_top
`default_nettype wire
